//--- qenc_map.svh
// Register map, field positions, reset values and timing counts of the encoder counter
// Functional notes
// [R1] Signed 32-bit count since last zeroing
// [R2] Signed 32-bit raw total, never zeroed
// [R3] Armed index pulse zeroes the count
// [R4] Index event clears the arm bit
// [R5] Host reset level holds count at zero
// [R6] Host itself releases the reset bit
// [R7] Mode bit: quadrature or up/down
// [R8] Up/down: rising A, direction from B
// [R9] Quadrature counts every edge, four per line
// [R10] Filter on: 15 stable clocks needed
// [R11] Filter off: 3 stable clocks needed
// [R12] Inputs sampled on 33 or 50 MHz clock
// [R13] Index polarity selects rising or falling edge
// [R14] Gating bit qualifies index by gate input
// [R15] Gate polarity: bit set means active low
// [R16] Three or four inputs fixed at build
// [R17] A leads increments, illegal jumps ignored
// [R18] Atomic count reads, readable arm bit
`ifndef QENC_MAP_SVH
`define QENC_MAP_SVH
`define QENC_OFF_CTRL 12'h000
`define QENC_OFF_COUNT 12'h004
`define QENC_OFF_RAW 12'h008
`define QENC_OFF_STATUS 12'h00c
`define QENC_BIT_MODE 0
`define QENC_BIT_FILTER 1
`define QENC_BIT_IDX_POL 2
`define QENC_BIT_GATE_EN 3
`define QENC_BIT_GATE_POL 4
`define QENC_BIT_ARM 5
`define QENC_BIT_HOST_RST 6
`define QENC_CTRL_RESET 7'h02
`define QENC_CTRL_WMASK 7'h7f
`define QENC_STABLE_LONG 15
`define QENC_STABLE_SHORT 3
`define QENC_CLK_MHZ 50
`endif

//--- qenc_pkg.sv
// Types shared by the encoder counter files
package qenc_pkg;
  typedef enum logic [2:0] {
    APB_IDLE = 3'b001,
    APB_SETUP = 3'b010,
    APB_ACCESS = 3'b100
  } apb_state_t;
  typedef logic signed [31:0] count_t;
endpackage : qenc_pkg

//--- qenc_filter.sv
// Synchroniser and stability filter for one encoder input line
`timescale 1ns/10ps
`include "qenc_map.svh"
module qenc_filter #(
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic long_mode,
  input wire logic pin,
  output logic level
);
  logic sync1;
  logic sync2;
  logic [CNT_W-1:0] stable;
  logic [CNT_W-1:0] need;

  // Refused at elaboration: 15 stable samples need four bits
  generate
    if (CNT_W < 4)
    begin : g_bad_width
      $error("qenc_filter: CNT_W too small for stable count");
    end
  endgenerate

  // Two flops before anything reads the pin [R12]
  always_ff @(posedge clk)
  begin
    sync1 <= pin;
    sync2 <= sync1;
  end

  assign need = long_mode ? CNT_W'(`QENC_STABLE_LONG) : CNT_W'(`QENC_STABLE_SHORT); // [R10] [R11]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stable <= '0;
      level <= 1'b0;
    end
    else if (sync2 == level)
    begin
      stable <= '0;
    end
    else if (stable + CNT_W'(1) >= need)
    begin
      // Accept after need consecutive differing samples [R10] [R11]
      level <= sync2;
      stable <= '0;
    end
    else
    begin
      stable <= stable + CNT_W'(1);
    end
  end

  a_filter_short: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
    (!long_mode && $changed(level)) |-> $past(sync2, 1) != $past(level, 3))
    else $error("filter accepted a change too early");
endmodule : qenc_filter

//--- qenc_counter.sv
// Quadrature encoder counter with index zeroing and APB register access
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "qenc_map.svh"
module qenc_counter #(
  parameter bit HAS_GATE = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx,
  input wire logic enc_gate,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic index_seen
);
  // ----------------------------------------
  // Control and filtered inputs
  // ----------------------------------------
  logic [6:0] ctrl;
  logic a_f;
  logic b_f;
  logic idx_f;
  logic gate_f;
  logic a_d;
  logic b_d;
  logic idx_d;
  qenc_pkg::count_t count;
  qenc_pkg::count_t raw;
  qenc_pkg::apb_state_t apb_state;
  qenc_pkg::apb_state_t next_apb_state;
  logic step_up;
  logic step_dn;
  logic idx_edge;
  logic gate_ok;
  logic idx_event;
  logic wr_ctrl;
  logic [6:0] next_ctrl;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Filter counts only mean something at the two sample rates [R12]
  generate
    if (`QENC_CLK_MHZ != 50 && `QENC_CLK_MHZ != 33)
    begin : g_bad_clk
      $error("qenc_counter: sample clock must be 33 or 50 MHz");
    end
  endgenerate

  // Filters sample on the block clock; the inputs are async pins [R12]
  qenc_filter #(.CNT_W(4)) u_fa (.clk(clk), .reset_n(reset_n),
    .long_mode(ctrl[`QENC_BIT_FILTER]), .pin(enc_a), .level(a_f));
  qenc_filter #(.CNT_W(4)) u_fb (.clk(clk), .reset_n(reset_n),
    .long_mode(ctrl[`QENC_BIT_FILTER]), .pin(enc_b), .level(b_f));
  qenc_filter #(.CNT_W(4)) u_fi (.clk(clk), .reset_n(reset_n),
    .long_mode(ctrl[`QENC_BIT_FILTER]), .pin(enc_idx), .level(idx_f));

  // Gate input exists only in four-input builds [R16]
  generate
    if (HAS_GATE)
    begin : g_gate
      qenc_filter #(.CNT_W(4)) u_fg (.clk(clk), .reset_n(reset_n),
        .long_mode(ctrl[`QENC_BIT_FILTER]), .pin(enc_gate), .level(gate_f));
    end
    else
    begin : g_nogate
      assign gate_f = 1'b0;
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      a_d <= 1'b0;
      b_d <= 1'b0;
      idx_d <= 1'b0;
    end
    else
    begin
      a_d <= a_f;
      b_d <= b_f;
      idx_d <= idx_f;
    end
  end

  // ----------------------------------------
  // Step decode
  // ----------------------------------------
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [3:0] t;
    t = {prev, cur};
    // Gray order 00-10-11-01 with A as high bit: A leads gives +1 [R17]
    case (t)
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b01;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b10;
      default: quad_step = 2'b00; // No move or illegal double jump [R17]
    endcase
  endfunction : quad_step

  always_comb
  begin
    logic [1:0] q;
    q = quad_step({a_d, b_d}, {a_f, b_f});
    if (ctrl[`QENC_BIT_MODE])
    begin
      // Rising A counts, B level gives direction [R7] [R8]
      step_up = a_f && !a_d && !b_f;
      step_dn = a_f && !a_d && b_f;
    end
    else
    begin
      // Every edge of A and B counts [R7] [R9]
      step_up = q[0];
      step_dn = q[1];
    end
  end

  // ----------------------------------------
  // Index qualification
  // ----------------------------------------
  assign idx_edge = ctrl[`QENC_BIT_IDX_POL] ? (idx_f && !idx_d) : (!idx_f && idx_d); // [R13]
  assign gate_ok = !ctrl[`QENC_BIT_GATE_EN] || (gate_f ^ ctrl[`QENC_BIT_GATE_POL]); // [R14] [R15]
  assign idx_event = idx_edge && gate_ok && ctrl[`QENC_BIT_ARM]; // [R3]

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      raw <= '0;
    end
    else if (step_up)
    begin
      raw <= raw + 32'sd1; // [R2]
    end
    else if (step_dn)
    begin
      raw <= raw - 32'sd1; // [R2]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      count <= '0;
    end
    else if (ctrl[`QENC_BIT_HOST_RST] || idx_event)
    begin
      count <= '0; // [R3] [R5]
    end
    else if (step_up)
    begin
      count <= count + 32'sd1; // [R1]
    end
    else if (step_dn)
    begin
      count <= count - 32'sd1; // [R1]
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_comb
  begin
    case (apb_state)
      qenc_pkg::APB_IDLE: next_apb_state = psel ? qenc_pkg::APB_SETUP : qenc_pkg::APB_IDLE;
      qenc_pkg::APB_SETUP: next_apb_state = qenc_pkg::APB_ACCESS;
      qenc_pkg::APB_ACCESS: next_apb_state = psel ? qenc_pkg::APB_SETUP : qenc_pkg::APB_IDLE;
      default: next_apb_state = qenc_pkg::APB_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      apb_state <= qenc_pkg::APB_IDLE;
    end
    else if (psel && !penable)
    begin
      apb_state <= qenc_pkg::APB_SETUP;
    end
    else
    begin
      apb_state <= next_apb_state;
    end
  end

  // Answer registered at the end of setup, ready in the first access cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !(paddr == `QENC_OFF_CTRL || paddr == `QENC_OFF_COUNT ||
                   paddr == `QENC_OFF_RAW || paddr == `QENC_OFF_STATUS);
      // Snapshot at setup so a word cannot tear mid-transfer [R18]
      case (paddr)
        `QENC_OFF_CTRL: prdata <= {25'h0, ctrl};
        `QENC_OFF_COUNT: prdata <= count; // [R18]
        `QENC_OFF_RAW: prdata <= raw; // [R18]
        `QENC_OFF_STATUS: prdata <= {28'h0, gate_f, idx_f, b_f, a_f};
        default: prdata <= '0;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Access phase only: pready and the setup state both mark it [R18]
  assign wr_ctrl = psel && penable && pready && (apb_state == qenc_pkg::APB_SETUP) &&
    pwrite && pstrb[0] && paddr == `QENC_OFF_CTRL;

  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
    begin
      next_ctrl = pwdata[6:0] & `QENC_CTRL_WMASK;
    end
    // Event beats a concurrent arm write [R4]
    if (idx_event)
    begin
      next_ctrl[`QENC_BIT_ARM] = 1'b0;
    end
  end

  // Host reset bit is a plain level; only the host clears it [R6]
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl <= `QENC_CTRL_RESET;
    end
    else
    begin
      ctrl <= next_ctrl; // [R4]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      index_seen <= 1'b0;
    end
    else
    begin
      index_seen <= idx_event;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_host_reset_hold: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    ctrl[`QENC_BIT_HOST_RST] |=> count == 0)
    else $error("count not held at zero");
  a_index_zero: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    idx_event |=> count == 0 && !ctrl[`QENC_BIT_ARM] && index_seen)
    else $error("armed index did not zero count");
  a_arm_clear: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    idx_event |=> !ctrl[`QENC_BIT_ARM])
    else $error("arm bit not cleared");
  a_seen_pulse: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    index_seen |=> !index_seen)
    else $error("index event repeated without rearm");
  a_raw_track: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    step_up |=> raw == $past(raw) + 32'sd1)
    else $error("raw total missed a step");
  a_raw_down: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    step_dn |=> raw == $past(raw) - 32'sd1)
    else $error("raw total missed a down step");
  a_raw_steady: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    (!step_up && !step_dn) |=> raw == $past(raw))
    else $error("raw total moved without a step");
  a_count_step: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (step_up && !ctrl[`QENC_BIT_HOST_RST] && !idx_event) |=> count == $past(count) + 32'sd1)
    else $error("count missed a step");
  a_count_down: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (step_dn && !ctrl[`QENC_BIT_HOST_RST] && !idx_event) |=> count == $past(count) - 32'sd1)
    else $error("count missed a down step");
  a_count_steady: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (!step_up && !step_dn && !ctrl[`QENC_BIT_HOST_RST] && !idx_event) |=> count == $past(count))
    else $error("count moved without a step");
  a_updown_mode: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    (ctrl[`QENC_BIT_MODE] && (step_up || step_dn)) |-> a_f && !a_d)
    else $error("up/down counted without rising A");
  a_updown_dir: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    (ctrl[`QENC_BIT_MODE] && step_up) |-> !b_f)
    else $error("up/down direction wrong");
  a_quad_edges: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    (!ctrl[`QENC_BIT_MODE] && a_f != a_d && b_f == b_d) |-> step_up || step_dn)
    else $error("quadrature edge not counted");
  a_quad_dir: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
    (!ctrl[`QENC_BIT_MODE] && step_up) |-> (a_f != a_d) == (a_d == b_d))
    else $error("quadrature direction wrong");
  a_illegal_jump: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
    (!ctrl[`QENC_BIT_MODE] && a_f != a_d && b_f != b_d) |-> !step_up && !step_dn)
    else $error("illegal jump changed the count");
  a_gate_block: assert property (@(posedge clk) disable iff (!reset_n) // [R14] [R15]
    (ctrl[`QENC_BIT_GATE_EN] && !(gate_f ^ ctrl[`QENC_BIT_GATE_POL])) |-> !idx_event)
    else $error("gated index took effect");
  a_idx_polarity: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
    idx_event |-> idx_f == ctrl[`QENC_BIT_IDX_POL])
    else $error("index fired on wrong edge");
  a_apb_answer: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    (psel && !penable) |=> pready)
    else $error("apb answer late");
  a_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    (wr_ctrl && !idx_event) |=> ctrl == $past(pwdata[6:0]))
    else $error("control write did not land");
  a_read_count: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    (psel && !penable && !pwrite && paddr == `QENC_OFF_COUNT) |=> prdata == $past(count))
    else $error("count read not a snapshot");
  a_err_unmapped: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    (psel && !penable && paddr > `QENC_OFF_STATUS) |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");

  c_index: cover property (@(posedge clk) disable iff (!reset_n) idx_event);
  c_updown: cover property (@(posedge clk) disable iff (!reset_n) ctrl[`QENC_BIT_MODE] && step_dn);
  c_quad_down: cover property (@(posedge clk) disable iff (!reset_n) !ctrl[`QENC_BIT_MODE] && step_dn);
  c_host_reset: cover property (@(posedge clk) disable iff (!reset_n) ctrl[`QENC_BIT_HOST_RST] && step_up);
  c_gate_blocked: cover property (@(posedge clk) disable iff (!reset_n) ctrl[`QENC_BIT_GATE_EN] && idx_edge && !gate_ok);
endmodule : qenc_counter

//--- enc_model.sv
// Behavioural incremental encoder driving A, B, index and gate lines
`timescale 1ns/10ps
module enc_model (
  input wire logic clk,
  output logic enc_a,
  output logic enc_b,
  output logic enc_idx,
  output logic enc_gate
);
  logic [1:0] p = 2'd0;
  initial
  begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_idx = 1'b0;
    enc_gate = 1'b0;
  end
  // -------------------------------------------
  // Line changes
  // -------------------------------------------
  // Short holds probe the filter; long ones must always register
  task automatic put(input logic a, input logic b, input int hold);
    @(posedge clk);
    enc_a <= a;
    enc_b <= b;
    repeat (hold) @(posedge clk);
  endtask : put
  // Gray order 00,10,11,01: forward means A leads B; d of 2 is an illegal jump
  task automatic step(input int d, input int hold);
    p = p + d[1:0];
    put(p[0] ^ p[1], p[1], hold);
  endtask : step
  task automatic pins(input logic i, input logic g);
    @(posedge clk);
    enc_idx <= i;
    enc_gate <= g;
    repeat (24) @(posedge clk);
  endtask : pins
endmodule : enc_model

//--- tb.sv
// Self-checking bench for the encoder counter
`timescale 1ns/10ps
`include "qenc_map.svh"
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic enc_a;
  logic enc_b;
  logic enc_idx;
  logic enc_gate;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic index_seen;
  logic [32:0] q[$];
  logic [31:0] cnt = 32'h0;
  logic [31:0] raw = 32'h0;
  logic hrst = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int n_idx = 0;
  always #10 clk = ~clk;
  qenc_counter #(.HAS_GATE(1'b1)) dut_u (.clk(clk), .reset_n(reset_n), .enc_a(enc_a), .enc_b(enc_b),
    .enc_idx(enc_idx), .enc_gate(enc_gate), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .index_seen(index_seen));
  enc_model enc_u (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .enc_gate(enc_gate));
  // -------------------------------------------
  // Checking
  // -------------------------------------------
  task automatic chk(input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
      chk(q.pop_front(), {pslverr, prdata});
    if (index_seen === 1'b1)
      n_idx++;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // -------------------------------------------
  // Host side
  // -------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (t >= 50)
    begin
      n_fail++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [31:0] d);
    apb(1'b1, `QENC_OFF_CTRL, d);
  endtask : wr
  task automatic counts();
    rd(`QENC_OFF_COUNT, {1'b0, cnt});
    rd(`QENC_OFF_RAW, {1'b0, raw});
  endtask : counts
  // Host reset holds the count but never the raw total
  task automatic qs(input int d, input int n, input int hold);
    repeat (n)
    begin
      enc_u.step(d, hold);
      raw = raw + d;
      cnt = hrst ? 32'h0 : cnt + d;
    end
  endtask : qs
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  initial
  begin
    #400000;
    n_fail++;
    end_sim();
  end
  // -------------------------------------------
  // Tests
  // -------------------------------------------
  initial
  begin
    logic b;
    logic [31:0] c0;
    void'($urandom(74971));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(`QENC_OFF_CTRL, {1'b0, 32'h00000002});
    rd(12'h010, {1'b1, 32'h0});
    apb(1'b1, `QENC_OFF_COUNT, 32'h12345678);
    counts();
    fin("reset and map");
    qs(1, $urandom_range(3, 9), 24);
    qs(-1, 2, 24);
    enc_u.step(2, 24);
    counts();
    fin("quadrature");
    wr(32'h42);
    hrst = 1'b1;
    qs(1, 2, 24);
    counts();
    wr(32'h02);
    hrst = 1'b0;
    qs(1, 1, 24);
    counts();
    fin("host reset");
    wr(32'h26);
    enc_u.pins(1'b1, 1'b0);
    enc_u.pins(1'b0, 1'b0);
    cnt = 32'h0;
    rd(`QENC_OFF_CTRL, {1'b0, 32'h06});
    counts();
    qs(-1, 2, 24);
    wr(32'h22);
    enc_u.pins(1'b1, 1'b0);
    rd(`QENC_OFF_CTRL, {1'b0, 32'h22});
    counts();
    enc_u.pins(1'b0, 1'b0);
    cnt = 32'h0;
    rd(`QENC_OFF_CTRL, {1'b0, 32'h02});
    counts();
    fin("index");
    qs(1, 3, 24);
    wr(32'h2e);
    enc_u.pins(1'b1, 1'b0);
    enc_u.pins(1'b0, 1'b0);
    rd(`QENC_OFF_CTRL, {1'b0, 32'h2e});
    counts();
    wr(32'h3e);
    enc_u.pins(1'b1, 1'b0);
    enc_u.pins(1'b0, 1'b0);
    cnt = 32'h0;
    rd(`QENC_OFF_CTRL, {1'b0, 32'h1e});
    counts();
    chk(33'd3, 33'(n_idx));
    rd(`QENC_OFF_STATUS, {1'b0, 28'h0, enc_gate, enc_idx, enc_b, enc_a});
    fin("index gating");
    wr(32'h02);
    c0 = cnt;
    qs(1, 1, 8);
    rd(`QENC_OFF_COUNT, {1'b0, c0});
    repeat (24) @(posedge clk);
    counts();
    wr(32'h00);
    qs(1, 1, 8);
    rd(`QENC_OFF_COUNT, {1'b0, cnt});
    repeat (24) @(posedge clk);
    fin("filter");
    wr(32'h03);
    enc_u.put(1'b0, 1'b0, 24);
    repeat ($urandom_range(4, 8))
    begin
      b = 1'($urandom_range(0, 1));
      enc_u.put(1'b0, b, 24);
      enc_u.put(1'b1, b, 24);
      cnt = cnt + (b ? 32'hffffffff : 32'h1);
      raw = raw + (b ? 32'hffffffff : 32'h1);
    end
    counts();
    fin("up down");
    end_sim();
  end
endmodule : tb
